// ==== src/lrf_pkg.sv ====
// shared constants and types of the led row fault manager
package lrf_pkg;
  // ==========================================================
  // geometry and timing
  localparam int          ROWS        = 6;
  localparam int          CLK_NS      = 10;
  localparam int          TICK_NS     = 1000;
  localparam int          TICK_CYC    = TICK_NS / CLK_NS;
  localparam logic [15:0] SS_US_RST   = 16'h03E8;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0]  OFS_CTRL    = 8'h00;
  localparam logic [7:0]  OFS_STATUS  = 8'h04;
  localparam logic [7:0]  OFS_ROWS    = 8'h08;
  localparam logic [7:0]  OFS_COUNT   = 8'h0C;

  // ==========================================================
  // field positions
  localparam int          CTRL_SWEN   = 0;
  localparam int          CTRL_SS_LSB = 16;
  localparam logic        SWEN_RST    = 1'b1;
  localparam int          ST_STATE    = 0;
  localparam int          ST_FAULT    = 2;
  localparam int          ST_HARD     = 3;
  localparam int          ST_MODE     = 4;
  localparam int          ST_EN       = 5;
  localparam int          ST_OCP      = 6;
  localparam int          ROWS_OPEN   = 0;
  localparam int          ROWS_SHORT  = 8;
  localparam int          CNT_OPEN    = 0;
  localparam int          CNT_SHORT   = 8;

  // ==========================================================
  // supervisor states
  typedef enum logic [1:0] {
    LRF_OFF     = 2'b00,
    LRF_SOFT    = 2'b01,
    LRF_RUN     = 2'b10,
    LRF_LATCHED = 2'b11
  } lrf_state_t;
endpackage

// ==== src/lrf_sync_if.sv ====
// synchronised pin levels passed between the fault manager modules
`timescale 1ns/1ps
interface lrf_sync_if #(parameter int N = 6);
  logic [N-1:0] row_open;
  logic [N-1:0] row_over;
  logic         mode;
  logic         enable;
  logic         dim;
  logic         uv_low;
  logic         uv_high;
  logic         ocp;
  logic         ovp;
  logic         therm;
  modport src (output row_open, row_over, mode, enable, dim, uv_low, uv_high, ocp, ovp, therm);
  modport dst (input  row_open, row_over, mode, enable, dim, uv_low, uv_high, ocp, ovp, therm);
endinterface : lrf_sync_if

// ==== src/lrf_sync.sv ====
// two-stage synchronisers for every asynchronous input
`timescale 1ns/1ps
module lrf_sync #(
  parameter int N = 6
) (
  input  wire logic         clk_i,
  input  wire logic         srst_i,
  input  wire logic [N-1:0] row_open_i,
  input  wire logic [N-1:0] row_over_i,
  input  wire logic         mode_i,
  input  wire logic         enable_i,
  input  wire logic         dim_i,
  input  wire logic         uv_low_i,
  input  wire logic         uv_high_i,
  input  wire logic         ocp_i,
  input  wire logic         ovp_i,
  input  wire logic         therm_i,
  lrf_sync_if.src           sy
);
  localparam int W = 2 * N + 8;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } lrf_sync_st_t;

  lrf_sync_st_t r;
  lrf_sync_st_t next_r;

  // ==========================================================
  // first stage feeds only the second
  always_comb begin
    next_r    = r;
    next_r.s1 = {row_open_i, row_over_i, mode_i, enable_i, dim_i, uv_low_i,
                 uv_high_i, ocp_i, ovp_i, therm_i};
    next_r.s2 = r.s1;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // outputs taken from the second stage
  assign {sy.row_open, sy.row_over, sy.mode, sy.enable, sy.dim, sy.uv_low,
          sy.uv_high, sy.ocp, sy.ovp, sy.therm} = r.s2;
endmodule : lrf_sync

// ==== src/lrf_por.sv ====
// power-on reset event from regulator under-voltage levels
`timescale 1ns/1ps
module lrf_por #(
  parameter int N = 6
) (
  input  wire logic clk_i,
  input  wire logic srst_i,
  lrf_sync_if.dst   sy,
  output logic      por_o
);
  typedef struct packed {
    logic armed;
    logic pulse;
  } lrf_por_st_t;

  lrf_por_st_t r;
  lrf_por_st_t next_r;

  // ==========================================================
  // arm on fall below lower level, fire on rise above upper
  always_comb begin
    next_r       = r;
    next_r.pulse = 1'b0;
    if (sy.uv_low) begin
      next_r.armed = 1'b1;
    end else if (r.armed && sy.uv_high) begin
      next_r.armed = 1'b0;
      next_r.pulse = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign por_o = r.pulse;
endmodule : lrf_por

// ==== src/lrf_top.sv ====
// led row fault supervisor with apb status and control registers
// How it works
// - mode high: open row dropped from regulation, others run, no fault
// - mode low: fault line pulled low on first open row
// - mode low: second open row latches the whole device off
// - row fault shutdown cleared only by enable toggle, CTRL_SWEN register bit toggle or power-on reset
// - power-on reset fires on regulator dip below low then rise above high
// - every active row compared against the shorted led threshold
// - mode high: every shorted row disconnected and fault pulled low
// - mode low: first shorted row disabled and fault pulled low
// - mode low: second shorted row latches the device off
// - an open-disabled row stays disabled even when it reconnects
// - short check stays on open-disabled rows, reconnection reports a fault
// - switch over-current turns the switch off, fault stays released
// - over-voltage or thermal event pulls fault low and latches off
// - open plus short on other rows: latch off mode low, disable mode high
// - enable low turns everything off and restarts soft-start, except after an over-voltage or thermal latch
// - open and short row checks act only after soft-start has completed
// - rows driven at full duty during soft-start, dimming ignored
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module lrf_top #(
  parameter int NUM_ROWS = lrf_pkg::ROWS
) (
  input  wire logic                clk_i,
  input  wire logic                srst_i,
  input  wire logic [NUM_ROWS-1:0] row_open_i,
  input  wire logic [NUM_ROWS-1:0] row_over_i,
  input  wire logic                mode_i,
  input  wire logic                enable_i,
  input  wire logic                dim_i,
  input  wire logic                uv_low_i,
  input  wire logic                uv_high_i,
  input  wire logic                ocp_i,
  input  wire logic                ovp_i,
  input  wire logic                therm_i,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  output logic                     fault_out_o,
  output logic                     fault_oe_n_o,
  output logic [NUM_ROWS-1:0]      row_en_o,
  output logic [NUM_ROWS-1:0]      row_drive_o,
  output logic                     power_sw_en_o,
  output logic                     device_on_o,
  output logic                     soft_done_o
);
  localparam int CW = $clog2(NUM_ROWS + 1);

  // ==========================================================
  // parameter check
  if (NUM_ROWS < 2 || NUM_ROWS > 8) begin : g_bad_rows
    $error("NUM_ROWS must lie between 2 and 8");
  end

  typedef logic [NUM_ROWS-1:0] lrf_rows_t;

  typedef struct packed {
    lrf_pkg::lrf_state_t st;
    logic [6:0]          div;
    logic                tick;
    logic [15:0]         ss_cnt;
    logic [15:0]         ss_len;
    logic                sw_en;
    lrf_rows_t           open_dis;
    lrf_rows_t           short_dis;
    logic [CW-1:0]       open_cnt;
    logic [CW-1:0]       short_cnt;
    logic                hard;
    logic                fault;
    logic                ocp_off;
    lrf_rows_t           row_en;
    lrf_rows_t           row_drive;
    logic                dev_on;
    logic                run;
    logic                sw_on;
    logic                pready;
    logic                pslverr;
    logic [31:0]         prdata;
  } lrf_top_st_t;

  lrf_top_st_t r;
  lrf_top_st_t next_r;
  logic        por;

  lrf_sync_if #(.N(NUM_ROWS)) sy ();

  // ==========================================================
  // input synchronisers and power-on reset detector
  lrf_sync #(.N(NUM_ROWS)) u_sync (
    .clk_i      (clk_i),
    .srst_i     (srst_i),
    .row_open_i (row_open_i),
    .row_over_i (row_over_i),
    .mode_i     (mode_i),
    .enable_i   (enable_i),
    .dim_i      (dim_i),
    .uv_low_i   (uv_low_i),
    .uv_high_i  (uv_high_i),
    .ocp_i      (ocp_i),
    .ovp_i      (ovp_i),
    .therm_i    (therm_i),
    .sy         (sy)
  );

  lrf_por #(.N(NUM_ROWS)) u_por (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .sy     (sy),
    .por_o  (por)
  );

  // count set bits of a row vector
  function automatic logic [CW-1:0] pop(input lrf_rows_t v);
    logic [CW-1:0] n;
    n = '0;
    for (int i = 0; i < NUM_ROWS; i++) begin
      n = n + CW'(v[i]);
    end
    return n;
  endfunction

  // ==========================================================
  // combinational next state
  always_comb begin
    logic      en_eff;
    logic      acc;
    logic      wr;
    lrf_rows_t new_open;
    lrf_rows_t new_short;
    lrf_rows_t all_open;
    lrf_rows_t all_short;
    logic      kill;
    en_eff    = sy.enable && r.sw_en;
    acc       = psel && penable;
    wr        = acc && r.pready && pwrite;
    new_open  = '0;
    new_short = '0;
    all_open  = r.open_dis;
    all_short = r.short_dis;
    kill      = 1'b0;
    next_r    = r;

    // one-microsecond tick divider
    next_r.tick = 1'b0;
    if (r.div == 7'(lrf_pkg::TICK_CYC - 1)) begin
      next_r.div  = '0;
      next_r.tick = 1'b1;
    end else begin
      next_r.div = r.div + 7'h01;
    end

    // supervisor sequence
    case (r.st)
      lrf_pkg::LRF_OFF: begin
        next_r.ss_cnt = '0;
        if (en_eff) begin
          next_r.st = lrf_pkg::LRF_SOFT;
        end
      end
      lrf_pkg::LRF_SOFT: begin
        if (r.tick) begin
          next_r.ss_cnt = r.ss_cnt + 16'h0001;
        end
        if (r.ss_cnt >= r.ss_len) begin
          next_r.st = lrf_pkg::LRF_RUN;
        end
      end
      lrf_pkg::LRF_RUN: begin
        new_open  = sy.row_open & r.row_en;
        new_short = sy.row_over & ~r.short_dis & (r.row_en | r.open_dis);
        all_open  = r.open_dis | new_open;
        all_short = r.short_dis | new_short;
        if (!sy.mode) begin
          // second fault of a kind, or open and short on other rows
          kill = (pop(all_open) >= CW'(2))
              || (pop(all_short) >= CW'(2))
              || (pop(all_open) != '0 && pop(all_short & ~all_open) != '0);
        end
        next_r.open_dis  = all_open;
        next_r.short_dis = all_short;
        next_r.open_cnt  = pop(all_open);
        next_r.short_cnt = pop(all_short);
        if (kill) begin
          next_r.st = lrf_pkg::LRF_LATCHED;
        end
      end
      lrf_pkg::LRF_LATCHED: begin
        next_r.ss_cnt = '0;
      end
      default: begin
        next_r.st = lrf_pkg::LRF_OFF;
      end
    endcase

    // over-voltage and thermal latch regardless of mode
    if (r.st != lrf_pkg::LRF_OFF && (sy.ovp || sy.therm)) begin
      next_r.st   = lrf_pkg::LRF_LATCHED;
      next_r.hard = 1'b1;
    end

    // power-on reset, or enable low without an over-voltage or thermal latch, restarts from off
    if (por || (!en_eff && !r.hard)) begin
      next_r.st        = lrf_pkg::LRF_OFF;
      next_r.open_dis  = '0;
      next_r.short_dis = '0;
      next_r.open_cnt  = '0;
      next_r.short_cnt = '0;
      next_r.ss_cnt    = '0;
      next_r.hard      = 1'b0;
    end

    // row enables and drive, full duty during soft-start
    next_r.ocp_off = sy.ocp;
    if (next_r.st == lrf_pkg::LRF_SOFT || next_r.st == lrf_pkg::LRF_RUN) begin
      next_r.row_en = ~(next_r.open_dis | next_r.short_dis);
    end else begin
      next_r.row_en = '0;
    end
    if (next_r.st == lrf_pkg::LRF_SOFT) begin
      next_r.row_drive = next_r.row_en;
    end else begin
      next_r.row_drive = next_r.row_en & {NUM_ROWS{sy.dim}};
    end

    // state decode registered so the status pins come from flops
    next_r.dev_on = next_r.st == lrf_pkg::LRF_SOFT || next_r.st == lrf_pkg::LRF_RUN;
    next_r.run    = next_r.st == lrf_pkg::LRF_RUN;
    next_r.sw_on  = next_r.dev_on && !next_r.ocp_off;

    // fault line: open rows count only in mode low
    next_r.fault = (next_r.st == lrf_pkg::LRF_LATCHED)
                || (next_r.short_dis != '0)
                || (!sy.mode && next_r.open_dis != '0);

    // apb slave: ready one cycle into the access phase
    next_r.pready  = acc && !r.pready;
    next_r.pslverr = 1'b0;
    if (acc && !r.pready) begin
      next_r.prdata = 32'h0000_0000;
      case (paddr)
        lrf_pkg::OFS_CTRL: begin
          next_r.prdata[lrf_pkg::CTRL_SWEN]         = r.sw_en;
          next_r.prdata[lrf_pkg::CTRL_SS_LSB +: 16] = r.ss_len;
        end
        lrf_pkg::OFS_STATUS: begin
          next_r.prdata[lrf_pkg::ST_STATE +: 2] = r.st;
          next_r.prdata[lrf_pkg::ST_FAULT]      = r.fault;
          next_r.prdata[lrf_pkg::ST_HARD]       = r.hard;
          next_r.prdata[lrf_pkg::ST_MODE]       = sy.mode;
          next_r.prdata[lrf_pkg::ST_EN]         = sy.enable;
          next_r.prdata[lrf_pkg::ST_OCP]        = r.ocp_off;
        end
        lrf_pkg::OFS_ROWS: begin
          next_r.prdata[lrf_pkg::ROWS_OPEN +: NUM_ROWS]  = r.open_dis;
          next_r.prdata[lrf_pkg::ROWS_SHORT +: NUM_ROWS] = r.short_dis;
        end
        lrf_pkg::OFS_COUNT: begin
          next_r.prdata[lrf_pkg::CNT_OPEN +: CW]  = r.open_cnt;
          next_r.prdata[lrf_pkg::CNT_SHORT +: CW] = r.short_cnt;
        end
        default: begin
          next_r.pslverr = 1'b1; // unmapped
        end
      endcase
    end
    if (wr && paddr == lrf_pkg::OFS_CTRL) begin
      next_r.sw_en  = pwdata[lrf_pkg::CTRL_SWEN];
      next_r.ss_len = pwdata[lrf_pkg::CTRL_SS_LSB +: 16];
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      r        <= '0;
      r.st     <= lrf_pkg::LRF_OFF;
      r.ss_len <= lrf_pkg::SS_US_RST;
      r.sw_en  <= lrf_pkg::SWEN_RST;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================
  // outputs straight from the state register
  assign prdata        = r.prdata;
  assign pready        = r.pready;
  assign pslverr       = r.pslverr;
  assign fault_out_o   = 1'b0 & r.fault; // open drain only pulls low
  assign fault_oe_n_o  = ~r.fault;
  assign row_en_o      = r.row_en;
  assign row_drive_o   = r.row_drive;
  assign power_sw_en_o = r.sw_on;
  assign device_on_o   = r.dev_on;
  assign soft_done_o   = r.run;
endmodule : lrf_top

// ==== dv/lrf_top_properties.sv ====
// port-level assertion checker for the led row fault supervisor
`timescale 1ns/1ps
module lrf_top_properties #(
  parameter int NUM_ROWS = 6
) (
  input wire logic                clk_i,
  input wire logic                srst_i,
  input wire logic                enable_i,
  input wire logic                ocp_i,
  input wire logic                ovp_i,
  input wire logic                therm_i,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire logic                fault_out_o,
  input wire logic                fault_oe_n_o,
  input wire logic [NUM_ROWS-1:0] row_en_o,
  input wire logic [NUM_ROWS-1:0] row_drive_o,
  input wire logic                power_sw_en_o,
  input wire logic                device_on_o,
  input wire logic                soft_done_o
);
  // ==========================================================
  // one clock domain
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  // ==========================================================
  // register bus answer
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
  property p_ready_answer; psel && $rose(penable) |=> pready; endproperty
  a_ready_answer: assert property (p_ready_answer) else $error("no answer after access");
  property p_err_qual; pslverr |-> pready; endproperty
  a_err_qual: assert property (p_err_qual) else $error("pslverr without pready");

  // ==========================================================
  // boost side events
  property p_drive_low; !fault_oe_n_o |-> !fault_out_o; endproperty
  a_drive_low: assert property (p_drive_low) else $error("fault line driven high");
  property p_ocp; ocp_i [*4] |-> !power_sw_en_o; endproperty
  a_ocp: assert property (p_ocp) else $error("switch on during over-current");
  property p_ovp; soft_done_o && ovp_i ##1 ovp_i [*3] |-> ##[0:2] (!fault_oe_n_o && !device_on_o);
  endproperty
  a_ovp: assert property (p_ovp) else $error("over-voltage not latched off");
  property p_therm;
    soft_done_o && therm_i ##1 therm_i [*3] |-> ##[0:2] (!fault_oe_n_o && !device_on_o);
  endproperty
  a_therm: assert property (p_therm) else $error("thermal event not latched off");
  property p_en_off; !enable_i [*4] |-> ##[0:1] (!device_on_o && !power_sw_en_o); endproperty
  a_en_off: assert property (p_en_off) else $error("device on with enable low");

  // ==========================================================
  // soft-start and row latching
  property p_soft_full; device_on_o && !soft_done_o && $past(device_on_o && !soft_done_o)
    |-> row_drive_o == row_en_o; endproperty
  a_soft_full: assert property (p_soft_full) else $error("rows dimmed in soft-start");
  property p_soft_quiet; device_on_o && !soft_done_o && $past(device_on_o && !soft_done_o)
    |-> fault_oe_n_o; endproperty
  a_soft_quiet: assert property (p_soft_quiet) else $error("fault in soft-start");
  property p_no_readmit; soft_done_o && $past(soft_done_o) |-> (row_en_o & ~$past(row_en_o)) == '0;
  endproperty
  a_no_readmit: assert property (p_no_readmit) else $error("row re-enabled in run");
endmodule // lrf_top_properties

bind lrf_top lrf_top_properties #(.NUM_ROWS(NUM_ROWS)) u_lrf_props (.clk_i, .srst_i, .enable_i,
  .ocp_i, .ovp_i, .therm_i, .psel, .penable, .pready, .pslverr, .fault_out_o, .fault_oe_n_o,
  .row_en_o, .row_drive_o, .power_sw_en_o, .device_on_o, .soft_done_o);

// ==== dv/lrf_led_model.sv ====
// behavioural model of the six led strings on the row pins
`timescale 1ns/1ps
module lrf_led_model (
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  input  wire logic [5:0] broken_i,
  input  wire logic [5:0] shorted_i,
  input  wire logic [5:0] row_en_i,
  input  wire logic       device_on_i,
  output logic      [5:0] row_open_o,
  output logic      [5:0] row_over_o
);
  typedef struct packed { logic [5:0] gone; } lrf_led_st_t;
  lrf_led_st_t st;
  lrf_led_st_t next_st;
  // remember rows seen open until the device turns off
  always_comb begin
    next_st = st;
    next_st.gone = device_on_i ? (st.gone | row_open_o) : 6'h00;
  end
  always_ff @(posedge clk_i) begin
    st <= srst_i ? '0 : next_st;
  end
  // open only where the string is driven, high voltage on shorts and on reconnection
  assign row_open_o = row_en_i & broken_i & {6{device_on_i}};
  assign row_over_o = (shorted_i & row_en_i) | (st.gone & ~broken_i);
endmodule // lrf_led_model

// ==== dv/lrf_top_tb_top.sv ====
// self-checking bench of the led row fault supervisor
`timescale 1ns/1ps
module lrf_top_tb_top;
  logic        clk_i = 0, srst_i = 1, mode_i = 1, enable_i = 0, dim_i = 0, uv_low_i = 0;
  logic        uv_high_i = 1, ocp_i = 0, ovp_i = 0, therm_i = 0, psel = 0, penable = 0;
  logic        pwrite = 0, pready, pslverr, fault_out_o, fault_oe_n_o, power_sw_en_o, er;
  logic        device_on_o, soft_done_o;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [5:0]  broken = 6'h00, shorted = 6'h00, row_open_i, row_over_i, row_en_o, row_drive_o;
  int          err_total = 0, compares = 0, r1, r2;
  lrf_top #(.NUM_ROWS(6)) DUT (.clk_i, .srst_i, .row_open_i, .row_over_i, .mode_i, .enable_i,
    .dim_i, .uv_low_i, .uv_high_i, .ocp_i, .ovp_i, .therm_i, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .fault_out_o, .fault_oe_n_o, .row_en_o, .row_drive_o,
    .power_sw_en_o, .device_on_o, .soft_done_o);
  lrf_led_model u_led (.clk_i, .srst_i, .broken_i(broken), .shorted_i(shorted),
    .row_en_i(row_en_o), .device_on_i(device_on_o), .row_open_o(row_open_i),
    .row_over_o(row_over_i));
  // 100 MHz clock
  always #5 clk_i = ~clk_i;
  task automatic wt(input int n); repeat (n) @(posedge clk_i); endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // apb cycle, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_i); penable <= 1;
    do begin @(posedge clk_i); n++; end while (pready !== 1'b1 && n < 50);
    rd = prdata; er = pslverr; psel <= 0; penable <= 0;
    if (n >= 50) chk(0, 1);
    @(posedge clk_i);
  endtask
  // reference reaction to open and shorted row masks
  task automatic ref_chk(input logic [5:0] om, input logic [5:0] sm);
    logic lat;
    lat = !mode_i && ($countones(om | sm) >= 2);
    chk(device_on_o, !lat);
    chk(fault_oe_n_o, !((om != 0 && !mode_i) || sm != 0));
    chk(row_en_o, lat ? 6'h00 : 6'(~(om | sm)));
    chk(fault_out_o, 0);
  endtask
  task automatic restart(input logic m);
    int n;
    n = 0;
    broken <= 0; shorted <= 0; mode_i <= m; dim_i <= 0; enable_i <= 0; wt(6);
    chk(device_on_o, 0); chk(power_sw_en_o, 0);
    enable_i <= 1; wt(6);
    chk(row_drive_o, 6'h3F);
    while (soft_done_o !== 1'b1 && n < 3000) begin @(posedge clk_i); n++; end
    chk(soft_done_o, 1); wt(2);
  endtask
  task automatic test_done;
    $display("err_total %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // watchdog
  initial begin #600us; err_total++; test_done; end
  // main sequence
  initial begin
    void'($urandom(32'h7473));
    wt(8); srst_i <= 0; wt(1);
    chk(fault_oe_n_o, 1); chk(device_on_o, 0);
    apb(0, lrf_pkg::OFS_CTRL, 0); chk(rd, {lrf_pkg::SS_US_RST, 15'h0, lrf_pkg::SWEN_RST});
    apb(0, 8'h10, 0); chk(er, 1); chk(rd, 0);
    apb(1, lrf_pkg::OFS_CTRL, 32'h0002_0001); chk(er, 0);
    restart(1); broken <= 6'h14; wt(6); ref_chk(6'h14, 0);
    apb(0, lrf_pkg::OFS_COUNT, 0); chk(rd[3:0], 2);
    broken <= 6'h10; wt(6); ref_chk(6'h14, 6'h04);
    apb(0, lrf_pkg::OFS_ROWS, 0); chk(rd, 32'h0000_0414);
    r1 = $urandom % 6; r2 = (r1 + 1 + $urandom % 5) % 6;
    restart(0); broken <= 6'(1 << r1); wt(6); ref_chk(6'(1 << r1), 0);
    broken <= 6'((1 << r1) | (1 << r2)); wt(6); ref_chk(6'((1 << r1) | (1 << r2)), 0);
    restart(0); ref_chk(0, 0);
    for (int m = 0; m < 2; m++) begin
      restart(1'(m)); shorted <= 6'h01; wt(6); ref_chk(0, 6'h01);
      shorted <= 6'h21; wt(6); ref_chk(0, 6'h21);
      restart(1'(m)); broken <= 6'h02; wt(6); shorted <= 6'h10; wt(6);
      ref_chk(6'h02, 6'h10);
      restart(1'(m)); ocp_i <= 1; wt(6); chk(power_sw_en_o, 0); ref_chk(0, 0);
      ocp_i <= 0; wt(6); chk(power_sw_en_o, 1);
      if (m == 1) therm_i <= 1; else ovp_i <= 1;
      wt(6); ovp_i <= 0; therm_i <= 0; wt(2);
      chk(device_on_o, 0); chk(fault_oe_n_o, 0);
      enable_i <= 0; wt(6); enable_i <= 1; wt(6); chk(fault_oe_n_o, 0);
      apb(0, lrf_pkg::OFS_STATUS, 0); chk(rd, 32'h0000_002F | 32'(m << 4));
      uv_high_i <= 0; uv_low_i <= 1; wt(6); uv_low_i <= 0; uv_high_i <= 1; wt(6);
      restart(1'(m)); chk(fault_oe_n_o, 1);
    end
    restart(1);
    repeat (8) begin
      dim_i <= 1'($urandom % 2); wt(6); chk(row_drive_o, 6'h3F & {6{dim_i}});
    end
    test_done;
  end
endmodule // lrf_top_tb_top
